/* logic/rtcp_pkg.sv */
package rtcp_pkg;
  localparam logic [6:0] RTCP_SLAVE_ADDR = 7'h68;
  localparam logic RTCP_DIR_WRITE = 1'b0;
  localparam logic RTCP_DIR_READ = 1'b1;
  localparam int RTCP_BITS = 8;
  localparam int RTCP_CLK_HZ = 100_000_000;
  localparam int RTCP_SCL_STD_HZ = 100_000;
  localparam int RTCP_SCL_FAST_HZ = 400_000;
  // half scl period of the master at the chosen rate, rounded down
  localparam int RTCP_HALF_STD = RTCP_CLK_HZ / (2 * RTCP_SCL_STD_HZ);
  localparam int RTCP_HALF_FAST = RTCP_CLK_HZ / (2 * RTCP_SCL_FAST_HZ);
  localparam int RTCP_PTR_W = 8;
  localparam logic [7:0] RTCP_PTR_RESET = 8'h00;
  localparam int RTCP_REG_DEPTH = 256;
endpackage : rtcp_pkg

/* logic/rtcp_bus_if.sv */
interface rtcp_bus_if;
  logic scl_m_o;
  logic scl_m_oe_n;
  logic sda_m_o;
  logic sda_m_oe_n;
  logic sda_s_o;
  logic sda_s_oe_n;
  logic scl_line;
  logic sda_line;
  // open-drain resolution: low only where an enabled driver pulls low
  assign scl_line = !((!scl_m_oe_n) && !scl_m_o);
  assign sda_line = !(((!sda_m_oe_n) && !sda_m_o) || ((!sda_s_oe_n) && !sda_s_o));
  modport slave (input scl_line, input sda_line, output sda_s_o, output sda_s_oe_n);
  modport master (input scl_line, input sda_line, output scl_m_o, output scl_m_oe_n,
                  output sda_m_o, output sda_m_oe_n);
endinterface : rtcp_bus_if

/* logic/rtcp_sync.sv */
module rtcp_sync
  import rtcp_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o,
  output logic scl_rise_o,
  output logic scl_fall_o,
  output logic start_o,
  output logic stop_o
);
  typedef struct packed {
    logic [1:0] scl_m;
    logic [1:0] sda_m;
    logic scl_d;
    logic sda_d;
  } rtcp_sync_t;
  rtcp_sync_t s_reg, s_next;
  always_comb begin
    s_next = s_reg;
    if (ce_i) begin
      s_next.scl_m = {s_reg.scl_m[0], scl_i};
      s_next.sda_m = {s_reg.sda_m[0], sda_i};
      s_next.scl_d = s_reg.scl_m[1];
      s_next.sda_d = s_reg.sda_m[1];
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) s_reg <= '{scl_m: 2'b11, sda_m: 2'b11, scl_d: 1'b1, sda_d: 1'b1};
    else s_reg <= s_next;
  end
  assign scl_o = s_reg.scl_m[1];
  assign sda_o = s_reg.sda_m[1];
  assign scl_rise_o = ce_i && s_reg.scl_m[1] && !s_reg.scl_d;
  assign scl_fall_o = ce_i && !s_reg.scl_m[1] && s_reg.scl_d;
  // sda edge while scl stays high marks a bus condition
  assign start_o = ce_i && s_reg.scl_m[1] && s_reg.scl_d && !s_reg.sda_m[1] && s_reg.sda_d;
  assign stop_o = ce_i && s_reg.scl_m[1] && s_reg.scl_d && s_reg.sda_m[1] && !s_reg.sda_d;
endmodule : rtcp_sync

/* logic/rtcp_slave.sv */
// Summary of operation
// (RULE1) start opens, stop closes every transfer
// (RULE2) first byte is address plus direction
// (RULE3) respond only to address 1101000
// (RULE4) direction 0 means master writes
// (RULE5) direction 1 means slave sends data
// (RULE6) acknowledge matching address in both directions
// (RULE7) first written byte loads register pointer
// (RULE8) any number of data bytes, each acknowledged
// (RULE9) pointer advances after every data byte
// (RULE10) master ends a write with stop
// (RULE11) read starts at current pointer register
// (RULE12) pointer persists between transfers
// (RULE13) master nacks last read byte
// (RULE14) master makes all clocks and conditions
// (RULE15) repeated start re-parses an address byte
// (RULE16) all bytes shifted msb first
// (RULE17) release data line after master nack
// (RULE18) ack held low through ninth clock high
// (RULE19) works at 100kHz and 400kHz
// (RULE20) mismatch: no ack, idle until start
module rtcp_slave
  import rtcp_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = RTCP_SLAVE_ADDR
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  rtcp_bus_if.slave bus,
  output logic wr_en_o,
  output logic [7:0] wr_addr_o,
  output logic [7:0] wr_data_o,
  output logic [7:0] rd_addr_o,
  input wire logic [7:0] rd_data_i,
  output logic busy_o
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK
  } rtcp_state_t;
  typedef struct packed {
    rtcp_state_t st;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic rd;
    logic idx_done;
    logic [7:0] ptr;
    logic sda_low;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
  } rtcp_slave_t;
  rtcp_slave_t s_reg, s_next;
  logic scl_s, sda_s, scl_rise, scl_fall, start_c, stop_c;
  // scl is sampled like any input: edges found on clk_sys_i (RULE14) (RULE19)
  rtcp_sync u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .scl_i(bus.scl_line),
    .sda_i(bus.sda_line),
    .scl_o(scl_s),
    .sda_o(sda_s),
    .scl_rise_o(scl_rise),
    .scl_fall_o(scl_fall),
    .start_o(start_c),
    .stop_o(stop_c)
  );
  always_comb begin
    s_next = s_reg;
    if (ce_i) begin
      s_next.wr_en = 1'b0;
      if (start_c) begin
        s_next.st = ST_ADDR; // (RULE1) (RULE15)
        s_next.bit_cnt = 4'h0;
        s_next.sda_low = 1'b0;
      end else if (stop_c) begin
        s_next.st = ST_IDLE; // (RULE1)
        s_next.sda_low = 1'b0;
      end else begin
        case (s_reg.st)
          ST_IDLE: ;
          ST_ADDR, ST_RX: begin
            if (scl_rise) begin
              s_next.shreg = {s_reg.shreg[6:0], sda_s}; // (RULE16)
              s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
            end else if (scl_fall && s_reg.bit_cnt == 4'(RTCP_BITS)) begin
              s_next.bit_cnt = 4'h0;
              if (s_reg.st == ST_ADDR) begin
                if (s_reg.shreg[7:1] == SLAVE_ADDR) begin // (RULE2) (RULE3)
                  s_next.st = ST_ADDR_ACK;
                  s_next.sda_low = 1'b1; // (RULE6)
                  s_next.rd = s_reg.shreg[0];
                  s_next.idx_done = 1'b0;
                end else begin
                  s_next.st = ST_IDLE; // (RULE20)
                end
              end else begin
                s_next.st = ST_RX_ACK;
                s_next.sda_low = 1'b1; // (RULE8)
                if (!s_reg.idx_done) begin
                  s_next.ptr = s_reg.shreg; // (RULE7)
                  s_next.idx_done = 1'b1;
                end else begin
                  s_next.wr_en = 1'b1;
                  s_next.wr_addr = s_reg.ptr;
                  s_next.wr_data = s_reg.shreg;
                  s_next.ptr = s_reg.ptr + 8'h01; // (RULE9)
                end
              end
            end
          end
          ST_ADDR_ACK: begin
            // ack released only at the falling edge after the ninth high (RULE18)
            if (scl_fall) begin
              if (s_reg.rd == RTCP_DIR_READ) begin // (RULE5)
                s_next.st = ST_TX;
                s_next.shreg = rd_data_i; // (RULE11) (RULE12)
                s_next.sda_low = !rd_data_i[7]; // (RULE16)
                s_next.bit_cnt = 4'h1;
              end else begin
                s_next.st = ST_RX; // (RULE4)
                s_next.sda_low = 1'b0;
              end
            end
          end
          ST_RX_ACK: begin
            if (scl_fall) begin
              s_next.st = ST_RX; // (RULE18)
              s_next.sda_low = 1'b0;
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (s_reg.bit_cnt == 4'(RTCP_BITS)) begin
                s_next.st = ST_TX_ACK;
                s_next.sda_low = 1'b0;
                s_next.ptr = s_reg.ptr + 8'h01; // (RULE9)
              end else begin
                s_next.sda_low = !s_reg.shreg[7 - 3'(s_reg.bit_cnt)]; // (RULE16)
                s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
              end
            end
          end
          ST_TX_ACK: begin
            if (scl_rise) begin
              s_next.rd = sda_s; // nack seen as high on the ninth clock
            end else if (scl_fall) begin
              if (s_reg.rd) begin
                s_next.st = ST_IDLE; // (RULE13) (RULE17)
                s_next.sda_low = 1'b0;
              end else begin
                s_next.st = ST_TX;
                s_next.shreg = rd_data_i;
                s_next.sda_low = !rd_data_i[7];
                s_next.bit_cnt = 4'h1;
              end
              s_next.rd = RTCP_DIR_READ;
            end
          end
          default: s_next.st = ST_IDLE;
        endcase
      end
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_reg <= '{st: ST_IDLE, bit_cnt: 4'h0, shreg: 8'h00, rd: 1'b0, idx_done: 1'b0,
                 ptr: RTCP_PTR_RESET, sda_low: 1'b0, wr_en: 1'b0, wr_addr: 8'h00,
                 wr_data: 8'h00};
    end else begin
      s_reg <= s_next;
    end
  end
  assign bus.sda_s_o = 1'b0;
  assign bus.sda_s_oe_n = !s_reg.sda_low;
  assign wr_en_o = s_reg.wr_en;
  assign wr_addr_o = s_reg.wr_addr;
  assign wr_data_o = s_reg.wr_data;
  assign rd_addr_o = s_reg.ptr;
  assign busy_o = (s_reg.st != ST_IDLE);
endmodule : rtcp_slave

/* logic/rtcp_master.sv */
module rtcp_master
  import rtcp_pkg::*;
#(
  parameter int HALF = RTCP_HALF_FAST
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  rtcp_bus_if.master bus,
  input wire logic req_i,
  input wire logic [6:0] addr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  input wire logic last_i,
  input wire logic stop_i,
  output logic ready_o,
  output logic [7:0] rdata_o,
  output logic nack_o,
  output logic done_o
);
  typedef enum logic [2:0] {M_IDLE, M_START, M_BIT, M_HOLD, M_STOP} rtcp_mst_t;
  typedef struct packed {
    rtcp_mst_t st;
    logic [15:0] tick;
    logic ph;
    logic [3:0] bit_cnt;
    logic [8:0] sh;
    logic rd;
    logic first;
    logic scl_low;
    logic sda_low;
    logic [7:0] rdata;
    logic nack;
    logic done;
    logic sda_m1;
    logic sda_m2;
  } rtcp_m_t;
  rtcp_m_t s_reg, s_next;
  logic tick_end;
  assign tick_end = (s_reg.tick == 16'(HALF - 1));
  always_comb begin
    s_next = s_reg;
    if (ce_i) begin
      s_next.done = 1'b0;
      s_next.sda_m1 = bus.sda_line;
      s_next.sda_m2 = s_reg.sda_m1;
      s_next.tick = tick_end ? 16'h0 : s_reg.tick + 16'h1;
      case (s_reg.st)
        M_IDLE, M_HOLD: begin
          s_next.tick = 16'h0;
          if (req_i) begin
            if (s_reg.st == M_IDLE || s_reg.first) begin
              s_next.st = M_START;
              s_next.rd = rd_i;
              s_next.sh = {addr_i, rd_i, 1'b1};
              s_next.first = 1'b0;
              s_next.scl_low = 1'b0;
              s_next.sda_low = 1'b0;
            end else begin
              s_next.st = M_BIT;
              // read: release sda, ack unless last byte (RULE13)
              s_next.sh = s_reg.rd ? {8'hff, last_i} : {wdata_i, 1'b1};
            end
            s_next.bit_cnt = 4'h0;
            s_next.ph = 1'b0;
          end else if (stop_i && s_reg.st == M_HOLD) begin
            s_next.st = M_STOP; // (RULE10)
            s_next.ph = 1'b0;
            s_next.sda_low = 1'b1;
          end
        end
        M_START: if (tick_end) begin
          if (!s_reg.ph) begin
            s_next.sda_low = 1'b1; // start from M_IDLE only; first is clear in M_HOLD, so no repeated start (RULE14) (RULE15)
            s_next.ph = 1'b1;
          end else begin
            s_next.scl_low = 1'b1;
            s_next.st = M_BIT;
            s_next.ph = 1'b0;
          end
        end
        M_BIT: if (tick_end) begin
          if (!s_reg.ph) begin
            s_next.sda_low = !s_reg.sh[8]; // (RULE16)
            s_next.scl_low = 1'b0;
            s_next.ph = 1'b1;
          end else begin
            s_next.scl_low = 1'b1;
            s_next.ph = 1'b0;
            s_next.sh = {s_reg.sh[7:0], 1'b1};
            if (s_reg.bit_cnt < 4'h8) s_next.rdata = {s_reg.rdata[6:0], s_reg.sda_m2};
            else s_next.nack = s_reg.sda_m2;
            s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
            if (s_reg.bit_cnt == 4'h8) begin
              s_next.st = M_HOLD;
              s_next.done = 1'b1;
              s_next.sda_low = 1'b0;
            end
          end
        end
        M_STOP: if (tick_end) begin
          if (!s_reg.ph) begin
            s_next.scl_low = 1'b0;
            s_next.ph = 1'b1;
          end else begin
            s_next.sda_low = 1'b0;
            s_next.st = M_IDLE;
            s_next.first = 1'b1;
          end
        end
        default: s_next.st = M_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_reg <= '{st: M_IDLE, tick: 16'h0, ph: 1'b0, bit_cnt: 4'h0, sh: 9'h1ff, rd: 1'b0,
                 first: 1'b1, scl_low: 1'b0, sda_low: 1'b0, rdata: 8'h00, nack: 1'b0,
                 done: 1'b0, sda_m1: 1'b1, sda_m2: 1'b1};
    end else begin
      s_reg <= s_next;
    end
  end
  assign bus.scl_m_o = 1'b0;
  assign bus.scl_m_oe_n = !s_reg.scl_low;
  assign bus.sda_m_o = 1'b0;
  assign bus.sda_m_oe_n = !s_reg.sda_low;
  assign ready_o = (s_reg.st == M_IDLE) || (s_reg.st == M_HOLD);
  assign rdata_o = s_reg.rdata;
  assign nack_o = s_reg.nack;
  assign done_o = s_reg.done;
endmodule : rtcp_master

/* verification/rtcp_checker.sv */
module rtcp_checker
  import rtcp_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic scl_line,
  input wire logic sda_line,
  input wire logic sda_s_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl_q, sda_q, first, rise, nine, strt;
  logic [3:0] bitn;
  logic [7:0] sh;
  // mode: 1 write, 2 read, 3 quiet after mismatch or read nack
  logic [1:0] mode;
  assign rise = scl_line && !scl_q;
  assign nine = rise && bitn == 4'h8;
  assign strt = scl_line && scl_q && sda_q && !sda_line;
  always_ff @(posedge clk_sys_i) begin
    scl_q <= scl_line;
    sda_q <= sda_line;
    if (rst_i || strt) begin
      bitn <= 4'h0;
      first <= 1'b1;
      mode <= 2'h0;
    end else if (nine) begin
      bitn <= 4'h0;
      first <= 1'b0;
      if (first) begin
        mode <= (sh[7:1] != RTCP_SLAVE_ADDR) ? 2'h3 : {sh[0], !sh[0]};
      end else if (mode == 2'h2 && sda_line) begin
        mode <= 2'h3;
      end
    end else if (rise) begin
      bitn <= bitn + 4'h1;
      sh <= {sh[6:0], sda_line};
    end
  end
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  idle_high_a: assert property (
    $fell(rst_i) |-> scl_line && sda_line && sda_s_oe_n) else $error("bus not idle");
  addr_ack_a: assert property (
    nine && first && sh[7:1] == RTCP_SLAVE_ADDR |-> !sda_s_oe_n) else $error("no address ack");
  addr_nack_a: assert property (
    nine && first && sh[7:1] != RTCP_SLAVE_ADDR |-> sda_s_oe_n) else $error("foreign address ack");
  quiet_slave_a: assert property (
    mode == 2'h3 |-> sda_s_oe_n) else $error("slave drives while quiet");
  write_ack_a: assert property (
    nine && !first && mode == 2'h1 |-> !sda_s_oe_n) else $error("no data ack");
  read_release_a: assert property (
    nine && !first && mode == 2'h2 |-> sda_s_oe_n) else $error("slave holds master ack bit");
  ack_held_a: assert property (
    nine && !sda_s_oe_n |-> ##1 (!sda_s_oe_n && scl_line) [*8]) else $error("ack dropped");
  sda_change_low_a: assert property (
    $changed(sda_s_oe_n) |-> !scl_line) else $error("slave sda change while scl high");
  master_start_a: assert property (
    $fell(sda_line) && scl_line |-> sda_s_oe_n) else $error("slave made start");
  master_stop_a: assert property (
    $rose(sda_line) && scl_line |-> $past(sda_s_oe_n)) else $error("slave made stop");
  cover property (nine && mode == 2'h1);
  cover property (nine && mode == 2'h2 && sda_line);
  cover property (mode == 2'h3 && strt);
endmodule : rtcp_checker

/* verification/testbench.sv */
module testbench
  import rtcp_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, req_i = 1'b0, rd_i = 1'b0, last_i = 1'b0, stop_i = 1'b0;
  logic [6:0] addr_i = 7'h00;
  logic [7:0] wdata_i = 8'h00, ptr;
  logic ready_o, nack_o, done_o, wr_en_o, busy_o;
  logic [7:0] rdata_o, wr_addr_o, wr_data_o, rd_addr_o;
  logic [7:0] regs [256], model [256];
  logic [15:0] wlog [$];
  int fail_count = 0, total_checks = 0, cyc = 0;
  rtcp_bus_if u_bus ();
  rtcp_slave u_rtcp_slave (.clk_sys_i, .rst_i, .ce_i(1'b1), .bus(u_bus), .wr_en_o, .wr_addr_o,
    .wr_data_o, .rd_addr_o, .rd_data_i(regs[rd_addr_o]), .busy_o);
  rtcp_master #(.HALF(RTCP_HALF_FAST)) u_rtcp_master (.clk_sys_i, .rst_i, .ce_i(1'b1),
    .bus(u_bus), .req_i, .addr_i, .rd_i, .wdata_i, .last_i, .stop_i, .ready_o, .rdata_o,
    .nack_o, .done_o);
  rtcp_checker u_rtcp_checker (.clk_sys_i, .rst_i, .scl_line(u_bus.scl_line),
    .sda_line(u_bus.sda_line), .sda_s_oe_n(u_bus.sda_s_oe_n));
  initial begin
    forever #5 clk_sys_i = !clk_sys_i;
  end
  task automatic final_report;
    if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  // register file behind the slave
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (wr_en_o === 1'b1) begin
      regs[wr_addr_o] <= wr_data_o;
      wlog.push_back({wr_addr_o, wr_data_o});
    end
    if (cyc == 80000) begin
      fail_count++;
      final_report();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one master command: s issues stop, otherwise waits for the byte to finish
  task automatic xfer(input logic [6:0] a, input logic r, input logic [7:0] d, input logic l,
      input logic s);
    int n;
    @(negedge clk_sys_i);
    // a stop command must not raise req_i: in hold a request wins and sends a byte
    {req_i, addr_i, rd_i, wdata_i, last_i, stop_i} = {!s, a, r, d, l, s};
    while (ready_o !== 1'b1) @(negedge clk_sys_i);
    @(negedge clk_sys_i);
    req_i = 1'b0;
    stop_i = 1'b0;
    n = 0;
    while (n < 6000 && (s ? (ready_o !== 1'b1 || busy_o !== 1'b0) : done_o !== 1'b1)) begin
      @(negedge clk_sys_i);
      n++;
    end
    if (n == 6000) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, 8'h00, 8'h01);
    end
  endtask : xfer
  task automatic wr(input logic [7:0] idx, input int cnt);
    xfer(RTCP_SLAVE_ADDR, RTCP_DIR_WRITE, 8'h00, 1'b0, 1'b0);
    chk({7'h00, nack_o}, 8'h00);
    xfer(7'h00, RTCP_DIR_WRITE, idx, 1'b0, 1'b0);
    chk({7'h00, nack_o}, 8'h00);
    for (int i = 0; i < cnt; i++) begin
      xfer(7'h00, RTCP_DIR_WRITE, 8'(8'h81 + i), 1'b0, 1'b0);
      chk({7'h00, nack_o}, 8'h00);
      model[8'(idx + i)] = 8'(8'h81 + i);
    end
    xfer(7'h00, RTCP_DIR_WRITE, 8'h00, 1'b0, 1'b1);
    chk(8'(wlog.size()), 8'(cnt));
    for (int i = 0; i < cnt; i++) begin
      chk(wlog[i][15:8], 8'(idx + i));
      chk(wlog[i][7:0], 8'(8'h81 + i));
    end
    wlog.delete();
    ptr = 8'(idx + cnt);
  endtask : wr
  task automatic rd(input int cnt);
    xfer(RTCP_SLAVE_ADDR, RTCP_DIR_READ, 8'h00, 1'b0, 1'b0);
    chk({7'h00, nack_o}, 8'h00);
    for (int i = 0; i < cnt; i++) begin
      xfer(7'h00, RTCP_DIR_READ, 8'h00, i == cnt - 1, 1'b0);
      chk(rdata_o, model[ptr]);
      ptr++;
    end
    xfer(7'h00, RTCP_DIR_READ, 8'h00, 1'b0, 1'b1);
  endtask : rd
  initial begin
    for (int i = 0; i < 256; i++) begin
      regs[i] = 8'(i) ^ 8'ha5;
      model[i] = 8'(i) ^ 8'ha5;
    end
    repeat (10) @(negedge clk_sys_i);
    rst_i = 1'b0;
    ptr = RTCP_PTR_RESET;
    rd(1);
    wr(8'hfe, 3);
    wr(8'h40, 0);
    rd(3);
    rd(1);
    wr(8'hfe, 0);
    rd(3);
    xfer(RTCP_SLAVE_ADDR ^ 7'h01, RTCP_DIR_WRITE, 8'h00, 1'b0, 1'b0);
    chk({7'h00, nack_o}, 8'h01);
    xfer(7'h00, RTCP_DIR_WRITE, 8'h00, 1'b0, 1'b1);
    xfer(7'h28, RTCP_DIR_READ, 8'h00, 1'b0, 1'b0);
    chk({7'h00, nack_o}, 8'h01);
    xfer(7'h00, RTCP_DIR_READ, 8'h00, 1'b0, 1'b1);
    chk(8'(wlog.size()), 8'h00);
    final_report();
  end
endmodule : testbench
